// ---- verilog/switch_unit_pkg.sv ----
package switch_unit_pkg;

	// ***************************************************************
	// register indices (byte address is four times the index)
	// ***************************************************************
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_CONFIG = 8'h40;
	localparam logic [7:0] IDX_STATUS = 8'h41;
	localparam logic [7:0] IDX_LIMIT_LEFT = 8'h42;
	localparam logic [7:0] IDX_LIMIT_RIGHT = 8'h43;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h44;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h45;
	localparam logic [7:0] IDX_RAMP_LATCH = 8'h46;
	localparam logic [7:0] IDX_ENC_LATCH = 8'h47;
	localparam logic [7:0] IDX_STOP_DECEL = 8'h48;

	// ***************************************************************
	// field layouts
	// ***************************************************************
	typedef struct packed {
		logic halt_on_stall;
		logic latch_enc;
		logic latch_right_inact;
		logic latch_right_act;
		logic latch_left_inact;
		logic latch_left_act;
		logic limit_right_en;
		logic limit_left_en;
		logic ramped_halt;
		logic exchange_sides;
		logic pol_right;
		logic pol_left;
		logic enable_right;
		logic enable_left;
	} switch_cfg_t;

	typedef struct packed {
		logic stall_halt_flag;
		logic stop_right_effect;
		logic stop_left_effect;
		logic latch_right_ready;
		logic latch_left_ready;
		logic switch_right_active;
		logic switch_left_active;
	} switch_flags_t;

	typedef struct packed {
		logic stall;
		logic stop_right;
		logic stop_left;
		logic latch_right;
		logic latch_left;
	} irq_bits_t;

	localparam int CFG_W = 14;
	localparam int FLAGS_W = 7;
	localparam int IRQ_W = 5;

	// ***************************************************************
	// reset values and responses
	// ***************************************************************
	localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : switch_unit_pkg

// ---- verilog/reference_switch_limit_unit.sv ----
// Functional notes
// - left stop switch acts only while its enable bit 0 is set
// - right stop switch acts only while its enable bit 1 is set
// - polarity bits 2 and 3; zero means high stops, one means low stops
// - unswapped, left switch stops negative motion, right stops positive
// - swap bit set exchanges switches: right stops negative, left positive
// - ramped-halt bit clear forces velocity to zero at once on a stop
// - ramped-halt bit set ramps velocity down with the stop deceleration
// - bits 6 and 7 enable left and right virtual 32-bit position limits
// - enabled limit makes motion come to rest at the limit, never beyond
// - bits 8 to 11 capture ramp position on switch active/inactive edges
// - bit 12 also captures encoder position with each ramp capture
// - bit 13 stops the motor on a driver stall event
// - status bits 0 and 1 show live switch state, no read side effect
// - status bits 2 and 3 set on capture, clear on status read
// - status bits 4 and 5 show a switch stop currently in effect
// - status bit 6 sets on stall stop, clears on status read
`timescale 1ns/100ps
`default_nettype none

module reference_switch_limit_unit
	import switch_unit_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [switch_unit_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [switch_unit_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic stop_left_pin,
	input wire logic stop_right_pin,
	input wire logic stall_pin,
	input wire logic [31:0] ramp_position,
	input wire logic [31:0] encoder_position,
	input wire logic moving_positive,
	input wire logic moving_negative,
	output logic halt_hard,
	output logic halt_ramped,
	output logic [31:0] stop_decel,
	output logic block_negative,
	output logic block_positive,
	output logic clamp_low_en,
	output logic [31:0] clamp_low,
	output logic clamp_high_en,
	output logic [31:0] clamp_high,
	output logic irq
);
	import switch_unit_pkg::*;

	// ***************************************************************
	// declarations
	// ***************************************************************
	switch_cfg_t cfg_r;
	switch_flags_t flags;
	irq_bits_t irq_set;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [31:0] ramp_latch_r;
	logic [31:0] enc_latch_r;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_idx_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic do_write;
	logic ar_take;
	logic [7:0] ar_idx;
	logic status_read;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [31:0] wr_mask;
	logic [2:0] sync_a_r;
	logic [2:0] sync_b_r;
	logic left_act;
	logic right_act;
	logic stall_lvl;
	logic left_prev_r;
	logic right_prev_r;
	logic stall_prev_r;
	logic left_rise;
	logic left_fall;
	logic right_rise;
	logic right_fall;
	logic stall_rise;
	logic left_on;
	logic right_on;
	logic left_hit;
	logic right_hit;
	logic cap_left;
	logic cap_right;
	logic stop_left_r;
	logic stop_right_r;
	logic latch_left_r;
	logic latch_right_r;
	logic stall_flag_r;
	logic stall_set;
	logic limit_low_reached;
	logic limit_high_reached;
	logic stop_any;

	// ***************************************************************
	// write channel
	// ***************************************************************
	assign awready = ~aw_held_r;
	assign wready = ~w_held_r;
	assign do_write = aw_held_r & w_held_r & ~bvalid;
	assign wr_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
		{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			aw_idx_r <= 8'h00;
		end
		else if (awvalid && awready)
		begin
			aw_held_r <= 1'b1;
			aw_idx_r <= awaddr[ADDR_W-1:2];
		end
		else if (do_write)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r <= 1'b0;
			wdata_r <= WORD_RESET;
			wstrb_r <= 4'h0;
		end
		else if (wvalid && wready)
		begin
			w_held_r <= 1'b1;
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end
		else if (do_write)
			w_held_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			case (aw_idx_r)
				IDX_CONFIG, IDX_LIMIT_LEFT, IDX_LIMIT_RIGHT,
				IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_STOP_DECEL:
					bresp <= RESP_OKAY;
				default:
					bresp <= RESP_SLVERR;
			endcase
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// ***************************************************************
	// software registers
	// ***************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg_r <= CFG_RESET;
		else if (do_write && aw_idx_r == IDX_CONFIG)
			cfg_r <= (cfg_r & ~wr_mask[CFG_W-1:0])
				| (wdata_r[CFG_W-1:0] & wr_mask[CFG_W-1:0]);
	end

	// limits are write-only; software loads them before enabling
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			clamp_low <= WORD_RESET;
			clamp_high <= WORD_RESET;
			stop_decel <= WORD_RESET;
		end
		else if (do_write)
		begin
			if (aw_idx_r == IDX_LIMIT_LEFT)
				clamp_low <= (clamp_low & ~wr_mask) | (wdata_r & wr_mask);
			if (aw_idx_r == IDX_LIMIT_RIGHT)
				clamp_high <= (clamp_high & ~wr_mask) | (wdata_r & wr_mask);
			if (aw_idx_r == IDX_STOP_DECEL)
				stop_decel <= (stop_decel & ~wr_mask) | (wdata_r & wr_mask);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_mask_r <= IRQ_MASK_RESET;
		else if (do_write && aw_idx_r == IDX_IRQ_MASK && wstrb_r[0])
			irq_mask_r <= wdata_r[IRQ_W-1:0];
	end

	// ***************************************************************
	// read channel
	// ***************************************************************
	assign arready = ~rvalid;
	assign ar_take = arvalid & arready;
	assign ar_idx = araddr[ADDR_W-1:2];
	assign status_read = ar_take & (ar_idx == IDX_STATUS);

	always_comb
	begin
		rd_word = WORD_RESET;
		rd_hit = 1'b1;
		case (ar_idx)
			IDX_CONFIG: rd_word[CFG_W-1:0] = cfg_r;
			IDX_STATUS: rd_word[FLAGS_W-1:0] = flags;
			IDX_LIMIT_LEFT, IDX_LIMIT_RIGHT: rd_word = WORD_RESET;
			IDX_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_r;
			IDX_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_r;
			IDX_RAMP_LATCH: rd_word = ramp_latch_r;
			IDX_ENC_LATCH: rd_word = enc_latch_r;
			IDX_STOP_DECEL: rd_word = stop_decel;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= WORD_RESET;
			rresp <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ***************************************************************
	// switch inputs
	// ***************************************************************
	// two flops per pin before any logic looks at them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_a_r <= 3'h0;
			sync_b_r <= 3'h0;
		end
		else
		begin
			sync_a_r <= {stall_pin, stop_right_pin, stop_left_pin};
			sync_b_r <= sync_a_r;
		end
	end

	assign left_act = sync_b_r[0] ^ cfg_r.pol_left;
	assign right_act = sync_b_r[1] ^ cfg_r.pol_right;
	assign stall_lvl = sync_b_r[2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			left_prev_r <= 1'b0;
			right_prev_r <= 1'b0;
			stall_prev_r <= 1'b0;
		end
		else
		begin
			left_prev_r <= left_act;
			right_prev_r <= right_act;
			stall_prev_r <= stall_lvl;
		end
	end

	assign left_rise = left_act & ~left_prev_r;
	assign left_fall = ~left_act & left_prev_r;
	assign right_rise = right_act & ~right_prev_r;
	assign right_fall = ~right_act & right_prev_r;
	assign stall_rise = stall_lvl & ~stall_prev_r;

	// ***************************************************************
	// stop switches
	// ***************************************************************
	assign left_on = cfg_r.enable_left & left_act;
	assign right_on = cfg_r.enable_right & right_act;
	// moving into the side that each switch guards
	assign left_hit = cfg_r.exchange_sides ? moving_positive
		: moving_negative;
	assign right_hit = cfg_r.exchange_sides ? moving_negative
		: moving_positive;

	// stop holds until the switch goes inactive or is disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stop_left_r <= 1'b0;
			stop_right_r <= 1'b0;
		end
		else
		begin
			stop_left_r <= left_on & (stop_left_r | left_hit);
			stop_right_r <= right_on & (stop_right_r | right_hit);
		end
	end

	assign limit_low_reached = cfg_r.limit_left_en
		& ($signed(ramp_position) <= $signed(clamp_low));
	assign limit_high_reached = cfg_r.limit_right_en
		& ($signed(ramp_position) >= $signed(clamp_high));
	assign clamp_low_en = cfg_r.limit_left_en;
	assign clamp_high_en = cfg_r.limit_right_en;

	assign block_negative = (cfg_r.exchange_sides ? right_on : left_on)
		| limit_low_reached;
	assign block_positive = (cfg_r.exchange_sides ? left_on : right_on)
		| limit_high_reached;

	assign stop_any = stop_left_r | stop_right_r | stall_flag_r;
	assign halt_hard = stop_any & ~cfg_r.ramped_halt;
	assign halt_ramped = stop_any & cfg_r.ramped_halt;

	// ***************************************************************
	// stall stop
	// ***************************************************************
	assign stall_set = stall_rise & cfg_r.halt_on_stall;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stall_flag_r <= 1'b0;
		else
			stall_flag_r <= stall_set
				| (stall_flag_r & ~status_read);
	end

	// ***************************************************************
	// position capture
	// ***************************************************************
	assign cap_left = (left_rise & cfg_r.latch_left_act)
		| (left_fall & cfg_r.latch_left_inact);
	assign cap_right = (right_rise & cfg_r.latch_right_act)
		| (right_fall & cfg_r.latch_right_inact);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ramp_latch_r <= WORD_RESET;
			enc_latch_r <= WORD_RESET;
		end
		else if (cap_left || cap_right)
		begin
			ramp_latch_r <= ramp_position;
			if (cfg_r.latch_enc)
				enc_latch_r <= encoder_position;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			latch_left_r <= 1'b0;
			latch_right_r <= 1'b0;
		end
		else
		begin
			latch_left_r <= cap_left
				| (latch_left_r & ~status_read);
			latch_right_r <= cap_right
				| (latch_right_r & ~status_read);
		end
	end

	always_comb
	begin
		flags.switch_left_active = left_act;
		flags.switch_right_active = right_act;
		flags.latch_left_ready = latch_left_r;
		flags.latch_right_ready = latch_right_r;
		flags.stop_left_effect = stop_left_r;
		flags.stop_right_effect = stop_right_r;
		flags.stall_halt_flag = stall_flag_r;
	end

	// ***************************************************************
	// interrupt
	// ***************************************************************
	always_comb
	begin
		irq_set.latch_left = cap_left;
		irq_set.latch_right = cap_right;
		irq_set.stop_left = left_on & left_hit & ~stop_left_r;
		irq_set.stop_right = right_on & right_hit & ~stop_right_r;
		irq_set.stall = stall_set;
	end

	// write one clears; a new event in the same cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_status_r <= IRQ_MASK_RESET;
		else if (do_write && aw_idx_r == IDX_IRQ_STATUS && wstrb_r[0])
			irq_status_r <= irq_set
				| (irq_status_r & ~wdata_r[IRQ_W-1:0]);
		else
			irq_status_r <= irq_set | irq_status_r;
	end

	assign irq = |(irq_status_r & irq_mask_r);

endmodule : reference_switch_limit_unit

`default_nettype wire

// ---- testbench/switch_unit_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module switch_unit_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [31:0] ramp_position,
	input wire logic clamp_low_en,
	input wire logic [31:0] clamp_low,
	input wire logic block_negative,
	input wire logic halt_hard,
	input wire logic halt_ramped
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ********
	// register bus handshakes
	// ********
	a_write_answer: assert property (awvalid && awready && wvalid && wready
		|=> ##1 bvalid) else $error("write got no response");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read got no data");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_rvalid_drop: assert property (rvalid && rready |=> !rvalid)
		else $error("read data stayed after handshake");
	a_ar_refused: assert property (arready != rvalid)
		else $error("read address ready while data pending");
	// ********
	// motion stops
	// ********
	a_halt_kind: assert property (!(halt_hard && halt_ramped))
		else $error("both halt kinds at once");
	a_limit_low: assert property (clamp_low_en &&
		$signed(ramp_position) <= $signed(clamp_low) |-> block_negative)
		else $error("motion not blocked at left limit");
endmodule : switch_unit_assertions
`default_nettype wire

// ---- testbench/switch_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
module switch_partner (
	input wire logic aclk,
	input wire logic slow,
	input wire logic [2:0] want,
	output logic stop_left_pin,
	output logic stop_right_pin,
	output logic stall_pin
);
	logic [2:0] pins_r = 3'h0;
	logic [1:0] lag_r = 2'h0;
	// ********
	// contacts follow at once, or every fourth cycle when slow
	// ********
	always @(posedge aclk)
	begin
		lag_r <= lag_r + 2'h1;
		if (!slow || lag_r == 2'h3)
			pins_r <= want;
	end
	assign {stall_pin, stop_right_pin, stop_left_pin} = pins_r;
endmodule : switch_partner
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import switch_unit_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, slow = 1'h0;
	logic mneg = 1'h0, mpos = 1'h0;
	logic [31:0] wdata = '0, ramp = '0, enc = '0, got, v, rdata, sd, cl;
	logic [1:0] resp, bresp, rresp;
	logic [2:0] want = 3'h0;
	logic awready, wready, bvalid, arready, rvalid, sl, sr, sg;
	logic hh, hr, bn, bp, cle, che, irq;
	logic [31:0] ch;
	int num_errors = 0, checks_done = 0, seed = 32'hEF95, i, lo;

	reference_switch_limit_unit u_dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .stop_left_pin(sl),
		.stop_right_pin(sr), .stall_pin(sg), .ramp_position(ramp),
		.encoder_position(enc), .moving_positive(mpos),
		.moving_negative(mneg), .halt_hard(hh), .halt_ramped(hr),
		.stop_decel(sd), .block_negative(bn), .block_positive(bp),
		.clamp_low_en(cle), .clamp_low(cl), .clamp_high_en(che),
		.clamp_high(ch), .irq(irq));
	switch_partner u_partner (.aclk(aclk), .slow(slow), .want(want),
		.stop_left_pin(sl), .stop_right_pin(sr), .stall_pin(sg));

	initial
	begin
		forever #2.5 aclk = ~aclk;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
			if (bvalid)
				break;
		end
		bready <= 1'h0;
		resp = bresp;
		if (n == 50)
			give_verdict_late();
	endtask : wr

	task automatic rdr(input logic [7:0] idx);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
			if (rvalid)
				break;
		end
		rready <= 1'h0;
		got = rdata;
		resp = rresp;
		if (n == 50)
			give_verdict_late();
	endtask : rdr

	task automatic give_verdict_late;
		num_errors++;
		give_verdict();
	endtask : give_verdict_late

	initial
	begin
		repeat (100000) @(posedge aclk);
		give_verdict_late();
	end

	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		// ********
		// map, reset values, access kinds
		// ********
		rdr(8'h60);
		chk(32'(resp), 32'(RESP_SLVERR));
		wr(8'h60, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR));
		rdr(IDX_CONFIG);
		chk(got, 32'(CFG_RESET));
		for (i = 0; i < 4; i++)
		begin
			v = $random(seed);
			wr(IDX_CONFIG, v);
			rdr(IDX_CONFIG);
			chk(got, v & 32'h3FFF);
			wr(IDX_STOP_DECEL, v);
			chk(sd, v);
		end
		// ********
		// polarity and live switch state
		// ********
		for (i = 0; i < 16; i++)
		begin
			wr(IDX_CONFIG, 32'(i[1:0]) << 2);
			slow <= i[0];
			want <= {1'h0, i[3:2]};
			repeat (8) @(posedge aclk);
			rdr(IDX_STATUS);
			chk(32'(got[1:0]), 32'(i[3:2] ^ i[1:0]));
			rdr(IDX_STATUS);
			chk(32'(got[1:0]), 32'(i[3:2] ^ i[1:0]));
		end
		// ********
		// enable, side exchange and halt kind
		// ********
		mneg <= 1'h1;
		for (i = 0; i < 16; i++)
		begin
			v = 32'(i[0] & (i[3] == i[1]));
			want <= 3'h0;
			repeat (8) @(posedge aclk);
			wr(IDX_CONFIG, 32'({i[2], i[1], 2'h0, i[0], i[0]}));
			want <= i[3] ? 3'h2 : 3'h1;
			repeat (8) @(posedge aclk);
			chk(32'({hh, hr}), 32'({v[0] & !i[2], v[0] & i[2]}));
			chk(32'({bn, bp}), 32'({v[0], i[0] & !v[0]}));
			rdr(IDX_STATUS);
			chk(32'(got[5:4]), 32'({v[0] & i[3], v[0] & !i[3]}));
		end
		want <= 3'h0;
		mneg <= 1'h0;
		// ********
		// position capture and interrupt
		// ********
		wr(IDX_IRQ_MASK, 32'h1);
		wr(IDX_IRQ_STATUS, 32'h1F);
		rdr(IDX_STATUS);
		for (i = 0; i < 2; i++)
		begin
			rdr(IDX_ENC_LATCH);
			v = got;
			wr(IDX_CONFIG, i ? 32'h1200 : 32'h0100);
			ramp <= $random(seed);
			enc <= $random(seed);
			want <= 3'h1;
			repeat (8) @(posedge aclk);
			if (i)
			begin
				ramp <= $random(seed);
				want <= 3'h0;
				repeat (8) @(posedge aclk);
			end
			rdr(IDX_RAMP_LATCH);
			chk(got, ramp);
			rdr(IDX_ENC_LATCH);
			chk(got, i ? enc : v);
			rdr(IDX_STATUS);
			chk(32'(got[2]), 32'h1);
			rdr(IDX_STATUS);
			chk(32'(got[2]), 32'h0);
			chk(32'(irq), 32'h1);
			wr(IDX_IRQ_MASK, 32'h0);
			chk(32'(irq), 32'h0);
			wr(IDX_IRQ_MASK, 32'h1);
			wr(IDX_IRQ_STATUS, 32'h1);
			chk(32'(irq), 32'h0);
			want <= 3'h0;
			repeat (8) @(posedge aclk);
		end
		// ********
		// stall stop
		// ********
		for (i = 0; i < 2; i++)
		begin
			wr(IDX_CONFIG, i ? 32'h2000 : 32'h0);
			want <= 3'h4;
			repeat (8) @(posedge aclk);
			want <= 3'h0;
			chk(32'(hh), 32'(i));
			rdr(IDX_STATUS);
			chk(32'(got[6]), 32'(i));
			rdr(IDX_STATUS);
			chk(32'({got[6], hh}), 32'h0);
		end
		// ********
		// virtual limits, loaded before enabling
		// ********
		for (i = 0; i < 3; i++)
		begin
			lo = $random(seed) % 1000;
			wr(IDX_LIMIT_LEFT, lo);
			wr(IDX_LIMIT_RIGHT, lo + 500);
			wr(IDX_CONFIG, 32'h00C0);
			chk(32'({cle, che}), 32'h3);
			chk(cl, lo);
			chk(ch, lo + 500);
			for (int k = 2; k >= 0; k--)
			begin
				ramp <= (k == 0) ? lo : lo + 250 * k;
				repeat (2) @(posedge aclk);
				chk(32'({bn, bp}), k == 0 ? 32'h2 : k == 1 ? 32'h0 : 32'h1);
			end
		end
		rdr(IDX_LIMIT_LEFT);
		chk(got, 32'h0);
		give_verdict();
	end
endmodule : tb_top

bind reference_switch_limit_unit switch_unit_assertions u_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .ramp_position(ramp_position),
	.clamp_low_en(clamp_low_en), .clamp_low(clamp_low),
	.block_negative(block_negative), .halt_hard(halt_hard),
	.halt_ramped(halt_ramped));
`default_nettype wire
